// File: verilog/fault_sig_pkg.sv
// Package: sample encodings, expected patterns and fault classes
package fault_sig_pkg;

	// Command family under which a pair of samples is taken
	typedef enum logic {
		CMD_AC_TEST,
		CMD_DC_EXTEST
	} test_cmd_e;

	// Verdict after both samples of one command are in
	typedef enum logic [2:0] {
		VERDICT_NONE,
		VERDICT_PASS,
		VERDICT_OPEN_OR_POWER,
		VERDICT_GROUND,
		VERDICT_LEG_SHORT,
		VERDICT_OTHER
	} verdict_e;

	// One capture of the two test receiver cells
	typedef struct packed {
		logic pos;
		logic neg;
	} leg_pair_s;

	// Per-leg classification result
	typedef struct packed {
		logic open_or_power;
		logic ground;
	} leg_fault_s;

	// Fault-free patterns, identical for both commands
	localparam logic [1:0] GOOD_SAMPLE0 = 2'h1; // pos 0, neg 1
	localparam logic [1:0] GOOD_SAMPLE1 = 2'h2; // pos 1, neg 0

	localparam logic       SAMPLE_IDX_RESET  = 1'h0;
	localparam logic [2:0] VERDICT_RESET     = 3'h0;

endpackage

// File: verilog/leg_classifier.sv
// Module: classifies one receive leg from its two captures
`timescale 1ns/10ps
module leg_classifier
	import fault_sig_pkg::*;
(
	input  wire logic       cap0_i,
	input  wire logic       cap1_i,
	input  wire test_cmd_e  cmd_i,
	output leg_fault_s      fault_o
);

	always_comb begin
		fault_o = '0;
		if (cmd_i == CMD_AC_TEST) begin
			// Open and solid power short both read 0 under pulse test
			fault_o.open_or_power = ~cap0_i & ~cap1_i;
			fault_o.ground        = ~cap0_i & ~cap1_i;
		end else begin
			fault_o.open_or_power = cap0_i & cap1_i;
			fault_o.ground        = ~cap0_i & ~cap1_i;
		end
	end

endmodule

// File: verilog/dc_coupled_fault_signature.sv
// Module: DC-coupled receive pair boundary-scan fault signature checker
`timescale 1ns/10ps
module dc_coupled_fault_signature
	import fault_sig_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic       capture_i,
	input  wire logic       sample_idx_i,
	input  wire test_cmd_e  cmd_i,
	input  wire leg_pair_s  cells_i,
	output logic            done_o,
	output logic            fault_o,
	output verdict_e        verdict_o,
	output leg_fault_s      pos_fault_o,
	output leg_fault_s      neg_fault_o
);

	leg_pair_s  samp0_r;
	leg_pair_s  samp0_nxt;
	logic       have0_r;
	logic       have0_nxt;
	logic       done_r;
	logic       done_nxt;
	logic       fault_r;
	logic       fault_nxt;
	verdict_e   verdict_r;
	verdict_e   verdict_nxt;
	leg_fault_s pos_r;
	leg_fault_s pos_nxt;
	leg_fault_s neg_r;
	leg_fault_s neg_nxt;
	leg_fault_s pos_cls;
	leg_fault_s neg_cls;
	logic       dev;
	logic       same_legs;

	leg_classifier u_pos (
		.cap0_i  (samp0_r.pos),
		.cap1_i  (cells_i.pos),
		.cmd_i   (cmd_i),
		.fault_o (pos_cls)
	);

	leg_classifier u_neg (
		.cap0_i  (samp0_r.neg),
		.cap1_i  (cells_i.neg),
		.cmd_i   (cmd_i),
		.fault_o (neg_cls)
	);

	always_comb begin
		// Either command alone gives the same fault-free signature
		dev = (samp0_r != GOOD_SAMPLE0) ||
			(cells_i != GOOD_SAMPLE1);
		// Leg-to-leg short: both samples equal across legs
		same_legs = (samp0_r.pos == samp0_r.neg) &&
			(cells_i.pos == cells_i.neg);
	end

	always_comb begin
		samp0_nxt   = samp0_r;
		have0_nxt   = have0_r;
		done_nxt    = 1'b0;
		fault_nxt   = fault_r;
		verdict_nxt = verdict_r;
		pos_nxt     = pos_r;
		neg_nxt     = neg_r;
		if (capture_i) begin
			if (sample_idx_i == 1'b0) begin
				samp0_nxt = cells_i;
				have0_nxt = 1'b1;
			end else if (have0_r) begin
				have0_nxt = 1'b0;
				done_nxt  = 1'b1;
				fault_nxt = dev;
				pos_nxt   = pos_cls;
				neg_nxt   = neg_cls;
				// A pass may still hide an inductive power short
				if (!dev)
					verdict_nxt = VERDICT_PASS;
				else if (same_legs)
					verdict_nxt = VERDICT_LEG_SHORT;
				else if (pos_cls.ground && neg_cls.ground)
					verdict_nxt = VERDICT_OTHER;
				else if (cmd_i == CMD_DC_EXTEST &&
					(pos_cls.ground || neg_cls.ground))
					verdict_nxt = VERDICT_GROUND;
				else if (pos_cls.open_or_power || neg_cls.open_or_power)
					verdict_nxt = VERDICT_OPEN_OR_POWER;
				else
					verdict_nxt = VERDICT_OTHER;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			samp0_r   <= '0;
			have0_r   <= SAMPLE_IDX_RESET;
			done_r    <= 1'b0;
			fault_r   <= 1'b0;
			verdict_r <= VERDICT_NONE;
			pos_r     <= '0;
			neg_r     <= '0;
		end else begin
			samp0_r   <= samp0_nxt;
			have0_r   <= have0_nxt;
			done_r    <= done_nxt;
			fault_r   <= fault_nxt;
			verdict_r <= verdict_nxt;
			pos_r     <= pos_nxt;
			neg_r     <= neg_nxt;
		end
	end

	assign done_o      = done_r;
	assign fault_o     = fault_r;
	assign verdict_o   = verdict_r;
	assign pos_fault_o = pos_r;
	assign neg_fault_o = neg_r;

endmodule

// File: sim/fault_sig_properties.sv
// Checker for the fault signature block
`timescale 1ns/10ps
module fault_sig_checker import fault_sig_pkg::*; (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic capture_i,
	input wire logic sample_idx_i,
	input wire test_cmd_e cmd_i,
	input wire leg_pair_s cells_i,
	input wire logic done_o,
	input wire logic fault_o,
	input wire verdict_e verdict_o,
	input wire leg_fault_s pos_fault_o,
	input wire leg_fault_s neg_fault_o
);
	logic [1:0] c_r;
	logic v_r;
	wire [3:0] s = {c_r, cells_i};
	wire p = v_r && capture_i && sample_idx_i;
	always_ff @(posedge clock_i) c_r <= cells_i;
	always_ff @(posedge clock_i) v_r <= capture_i && !sample_idx_i && rst_n_i;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	property p_a; p |=> done_o; endproperty
	a_a: assert property (p_a) else $error("no done");
	property p_b; p && s == 4'h6 |=> verdict_o == VERDICT_PASS; endproperty
	a_b: assert property (p_b) else $error("no pass");
	property p_c; p && s != 4'h6 |=> fault_o; endproperty
	a_c: assert property (p_c) else $error("no fault");
	property p_e; p && s[3] == s[2] && s[1] == s[0] |=>
		verdict_o == VERDICT_LEG_SHORT; endproperty
	a_e: assert property (p_e) else $error("no short");
	property p_g; p && cmd_i && !s[3] && !s[1] |=> pos_fault_o == 2'h1;
	endproperty
	a_g: assert property (p_g) else $error("no ground");
	property p_h; p && cmd_i && s[3] && s[1] |=> pos_fault_o == 2'h2;
	endproperty
	a_h: assert property (p_h) else $error("no open");
	property p_ng; p && cmd_i && !s[2] && !s[0] |=> neg_fault_o == 2'h1;
	endproperty
	a_ng: assert property (p_ng) else $error("no neg ground");
	property p_no; p && cmd_i && s[2] && s[0] |=> neg_fault_o == 2'h2;
	endproperty
	a_no: assert property (p_no) else $error("no neg open");
endmodule
bind dc_coupled_fault_signature fault_sig_checker u_chk (.*);

// File: sim/far_end_model.sv
// Far-end model: transmitter and line with one chosen fault
`timescale 1ns/10ps
module far_end_model import fault_sig_pkg::*; (
	input wire logic [2:0] fault_i,
	input wire logic idx_i,
	input wire test_cmd_e cmd_i,
	output leg_pair_s cells_o
);
	always_comb begin
		cells_o = idx_i ? GOOD_SAMPLE1 : GOOD_SAMPLE0;
		case (fault_i)
			3'h1: cells_o.pos = cmd_i;
			3'h2: cells_o.pos = 1'h0;
			3'h3: cells_o.neg = cmd_i;
			3'h4: cells_o = 2'h0;
			3'h5: cells_o = 2'h3;
			default: ;
		endcase
	end
endmodule

// File: sim/dc_coupled_fault_signature_bench.sv
// Bench for the fault signature block
`timescale 1ns/10ps
module dc_coupled_fault_signature_bench import fault_sig_pkg::*; ;
	logic c = 1'h0, r = 1'h0, k = 1'h0, x = 1'h0, dn, fo;
	logic [2:0] f = 3'h0;
	test_cmd_e m = CMD_AC_TEST;
	leg_pair_s ce;
	verdict_e vd;
	leg_fault_s pf, nf;
	int num_errors = 0, tests_run = 0;
	logic [7:0] t [12] = '{8'h10, 8'h10, 8'hAC, 8'hA8, 8'hAC, 8'hB4,
		8'hA3, 8'hA2, 8'hCF, 8'hC5, 8'hC0, 8'hCA};
	always #50 c = ~c;
	dc_coupled_fault_signature DUT (.clock_i(c), .rst_n_i(r), .capture_i(k),
		.sample_idx_i(x), .cmd_i(m), .cells_i(ce), .done_o(dn), .fault_o(fo),
		.verdict_o(vd), .pos_fault_o(pf), .neg_fault_o(nf));
	far_end_model FAR (.fault_i(f), .idx_i(x), .cmd_i(m), .cells_o(ce));
	task chk(string n, logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task run(logic [2:0] a, test_cmd_e b, logic [7:0] e);
		@(posedge c) {f, k, x} <= {a, 2'h2};
		m <= b;
		@(posedge c) x <= 1'h1;
		@(posedge c) k <= 1'h0;
		#1 chk("done", dn, 8'h01);
		chk("legs", {fo, vd, pf, nf}, e);
	endtask
	task t_table;
		for (int i = 0; i < 12; i++)
			run(3'(i / 2), test_cmd_e'(i % 2), t[i]);
	endtask
	// A lone sample 1 must leave every output untouched
	task t_refuse;
		@(posedge c) {f, k, x} <= {3'h0, 2'h3};
		@(posedge c) k <= 1'h0;
		#1 chk("refused done", dn, 8'h00);
		chk("refused legs", {fo, vd, pf, nf}, 8'hCA);
	endtask
	task test_done;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge c);
		r <= 1'h1;
		#1 chk("reset done", dn, 8'h00);
		chk("reset legs", {fo, vd, pf, nf}, 8'h00);
		t_table();
		t_refuse();
		test_done();
	end
endmodule
